// [verilog/mbwa_arbiter.sv]
// What this block does
// RL1 - Fixed zero-wait RAM, PF0; boot ROM one wait
// RL2 - Flash waits from flash configuration input
// RL3 - Password locations always take sixteen waits
// RL4 - OTP waits programmable, minimum one
// RL5 - PF1/PF2 writes zero wait, reads two
// RL6 - Hold PF1 access while peripheral stretches it
// RL7 - Back-to-back PF1 writes add one cycle
// RL8 - Program read bus: 22-bit address, 32-bit data
// RL9 - Data buses: 32-bit address and data
// RL10 - Fetch, read, write are serialised, one grant at a time
// RL11 - Grant order: dwr, pwr, drd, prd, fetch
// RL12 - Never dwr with pwr, prd with fetch
// RL13 - Bridge merges onto 16-bit address bus
// RL14 - Frame two accepts only 16-bit accesses
// RL15 - Frame one accepts 16 and 32-bit accesses
// RL16 - Protected frames keep write-then-read order
// RL17 - Stall region wait count plus one cycle, plus extension
`include "mbwa_defs.svh"
module mbwa_arbiter
  import mbwa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  flash_wait,
  input  wire logic [4:0]  otp_wait,
  input  wire logic        protect_en,
  input  wire logic        fet_req,
  input  wire logic [21:0] fet_addr,
  input  wire logic        prd_req,
  input  wire logic [21:0] prd_addr,
  input  wire logic        pwr_req,
  input  wire logic [21:0] pwr_addr,
  input  wire logic [31:0] pwr_data,
  input  wire logic        drd_req,
  input  wire logic [31:0] drd_addr,
  input  wire logic        drd_wide,
  input  wire logic        dwr_req,
  input  wire logic [31:0] dwr_addr,
  input  wire logic [31:0] dwr_data,
  input  wire logic        dwr_wide,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        periph_hold,
  output logic             grant_valid,
  output logic [2:0]       grant_src,
  output logic             stall,
  output logic             done,
  output logic             access_error,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic             mem_we,
  output logic             mem_wide,
  output logic [3:0]       mem_region,
  output logic [31:0]      rdata,
  output logic             pbus_sel,
  output logic [15:0]      pbus_addr
);
  mbwa_state_t  state, next_state;
  mbwa_src_t    src, next_src;
  mbwa_region_t region, next_region;
  logic [4:0]   cnt, next_cnt;
  logic [31:0]  addr, next_addr;
  logic [31:0]  wdata, next_wdata;
  logic         we, next_we;
  logic         wide, next_wide;
  logic         last_pf1_wr, next_last_pf1_wr;
  logic         last_prot_wr, next_last_prot_wr;
  logic         done_r, next_done;
  logic [31:0]  rdata_r, next_rdata;
  logic         err, next_err;
  mbwa_src_t    pick;
  logic [31:0]  pick_addr, pick_wdata;
  logic         pick_we, pick_wide;
  mbwa_region_t pick_region;
  logic [4:0]   pick_wait;

  // Fixed priority pick; one grant at a time so pairs never collide
  always_comb begin
    pick       = MBWA_SRC_NONE;
    pick_addr  = 32'h0000_0000;
    pick_wdata = 32'h0000_0000;
    pick_we    = 1'b0;
    pick_wide  = 1'b1;
    if (dwr_req) begin // RL11 RL12
      pick = MBWA_SRC_DWR; pick_addr = dwr_addr; pick_wdata = dwr_data; // RL9
      pick_we = 1'b1; pick_wide = dwr_wide;
    end else if (pwr_req) begin
      pick = MBWA_SRC_PWR; pick_addr = {10'h000, pwr_addr}; pick_wdata = pwr_data;
      pick_we = 1'b1;
    end else if (drd_req) begin
      pick = MBWA_SRC_DRD; pick_addr = drd_addr; pick_wide = drd_wide; // RL9
    end else if (prd_req) begin
      pick = MBWA_SRC_PRD; pick_addr = {10'h000, prd_addr}; // RL8
    end else if (fet_req) begin
      pick = MBWA_SRC_FET; pick_addr = {10'h000, fet_addr}; // RL8
    end
  end

  // Region decode and per-region wait count
  always_comb begin
    pick_region = MBWA_REG_NONE;
    pick_wait   = `MBWA_WAIT_ZERO;
    if (pick_addr <= `MBWA_LOW_RAM_END) begin
      pick_region = MBWA_REG_RAM; // RL1
    end else if (pick_addr >= `MBWA_PF0_LO && pick_addr <= `MBWA_PF0_HI) begin
      pick_region = MBWA_REG_PF0; // RL1
    end else if (pick_addr >= `MBWA_PF1_LO && pick_addr <= `MBWA_PF1_HI) begin
      pick_region = MBWA_REG_PF1;
      pick_wait   = pick_we ? `MBWA_WAIT_ZERO : `MBWA_WAIT_PF_RD; // RL5
      if (pick_we && last_pf1_wr) pick_wait = `MBWA_WAIT_PF1_WWB; // RL7
    end else if (pick_addr >= `MBWA_PF2_LO && pick_addr <= `MBWA_PF2_HI) begin
      pick_region = MBWA_REG_PF2;
      pick_wait   = pick_we ? `MBWA_WAIT_ZERO : `MBWA_WAIT_PF_RD; // RL5
    end else if (pick_addr >= `MBWA_SRAM_LO && pick_addr <= `MBWA_SRAM_HI) begin
      pick_region = MBWA_REG_RAM; // RL1
    end else if (pick_addr >= `MBWA_OTP_LO && pick_addr <= `MBWA_OTP_HI) begin
      pick_region = MBWA_REG_OTP;
      pick_wait   = (otp_wait < `MBWA_WAIT_OTP_MIN) ? `MBWA_WAIT_OTP_MIN : otp_wait; // RL4
    end else if (pick_addr >= `MBWA_PWD_LO && pick_addr <= `MBWA_FLASH_HI) begin
      pick_region = MBWA_REG_PWD;
      pick_wait   = `MBWA_WAIT_PWD; // RL3
    end else if (pick_addr >= `MBWA_FLASH_LO && pick_addr <= `MBWA_FLASH_HI) begin
      pick_region = MBWA_REG_FLASH;
      pick_wait   = flash_wait; // RL2
    end else if (pick_addr >= `MBWA_BOOT_LO) begin
      pick_region = MBWA_REG_BOOT;
      pick_wait   = `MBWA_WAIT_BOOT; // RL1
    end
    // Read after write in a protected frame waits one alignment cycle
    // Frame reads already wait two, so the alignment cycle stacks on top of them
    if (protect_en && last_prot_wr && !pick_we &&
        (pick_region == MBWA_REG_PF1 || pick_region == MBWA_REG_PF2)) begin
      pick_wait = pick_wait + 5'h01; // RL16
    end
  end

  // Access sequencer: count waits, then honour peripheral stretch
  always_comb begin
    next_state        = state;
    next_src          = src;
    next_region       = region;
    next_cnt          = cnt;
    next_addr         = addr;
    next_wdata        = wdata;
    next_we           = we;
    next_wide         = wide;
    next_last_pf1_wr  = last_pf1_wr;
    next_last_prot_wr = last_prot_wr;
    next_done         = 1'b0;
    next_rdata        = rdata_r;
    next_err          = 1'b0;
    case (state)
      MBWA_IDLE: begin
        if (pick != MBWA_SRC_NONE) begin
          next_src    = pick;
          next_region = pick_region;
          next_addr   = pick_addr;
          next_wdata  = pick_wdata;
          next_we     = pick_we;
          next_wide   = pick_wide;
          next_cnt    = pick_wait; // RL17
          next_state  = MBWA_WAIT;
        end else begin
          next_last_pf1_wr  = 1'b0;
          next_last_prot_wr = 1'b0;
        end
      end
      MBWA_WAIT: begin
        if (cnt != 5'h00) begin
          next_cnt = cnt - 5'h01; // RL17
        end else if (region == MBWA_REG_PF1 && periph_hold) begin
          next_state = MBWA_EXT; // RL6
        end else begin
          next_state        = MBWA_IDLE;
          next_done         = 1'b1;
          next_rdata        = mem_rdata;
          // Frame two refuses 32-bit accesses; frame one takes both
          next_err          = (region == MBWA_REG_PF2) && wide; // RL14 RL15
          next_last_pf1_wr  = we && region == MBWA_REG_PF1; // RL7
          next_last_prot_wr = we && (region == MBWA_REG_PF1 || region == MBWA_REG_PF2);
        end
      end
      MBWA_EXT: begin
        if (!periph_hold) begin // RL6
          next_state        = MBWA_IDLE;
          next_done         = 1'b1;
          next_rdata        = mem_rdata;
          next_last_pf1_wr  = we;
          next_last_prot_wr = we;
        end
      end
      default: next_state = MBWA_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= MBWA_IDLE;
      src          <= MBWA_SRC_NONE;
      region       <= MBWA_REG_NONE;
      cnt          <= 5'h00;
      addr         <= 32'h0000_0000;
      wdata        <= 32'h0000_0000;
      we           <= 1'b0;
      wide         <= 1'b0;
      last_pf1_wr  <= 1'b0;
      last_prot_wr <= 1'b0;
      done_r       <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      err          <= 1'b0;
    end else begin
      state        <= next_state;
      src          <= next_src;
      region       <= next_region;
      cnt          <= next_cnt;
      addr         <= next_addr;
      wdata        <= next_wdata;
      we           <= next_we;
      wide         <= next_wide;
      last_pf1_wr  <= next_last_pf1_wr;
      last_prot_wr <= next_last_prot_wr;
      done_r       <= next_done;
      rdata_r      <= next_rdata;
      err          <= next_err;
    end
  end

  // Outputs; peripheral frames reach the bridge with a 16-bit address
  assign grant_valid  = state != MBWA_IDLE;
  assign grant_src    = src;
  assign stall        = state != MBWA_IDLE; // RL10
  assign done         = done_r;
  assign access_error = err;
  assign mem_addr     = addr;
  assign mem_wdata    = wdata;
  assign mem_we       = we && state != MBWA_IDLE;
  assign mem_wide     = wide;
  assign mem_region   = region;
  assign rdata        = rdata_r;
  assign pbus_sel     = state != MBWA_IDLE && (region == MBWA_REG_PF0 ||
                        region == MBWA_REG_PF1 || region == MBWA_REG_PF2); // RL13
  assign pbus_addr    = addr[15:0]; // RL13

  a_pwd_sixteen: assert property (@(posedge clk) disable iff (rst) // RL3
    (state == MBWA_IDLE && pick_region == MBWA_REG_PWD) |=> cnt == 5'h10)
    else $error("password wait not sixteen");
  // Boot access tail: the last stall cycle after the single wait, then the done pulse
  sequence s_boot_finish;
    !done ##1 done;
  endsequence
  a_boot_one: assert property (@(posedge clk) disable iff (rst) // RL1
    (state == MBWA_IDLE && pick_region == MBWA_REG_BOOT) |=> ##1 s_boot_finish)
    else $error("boot access not one wait");
  a_prio_write: assert property (@(posedge clk) disable iff (rst) // RL11
    (state == MBWA_IDLE && dwr_req) |=> grant_src == MBWA_SRC_DWR)
    else $error("data write not top priority");
  a_pf_read_two: assert property (@(posedge clk) disable iff (rst) // RL5
    (state == MBWA_IDLE && pick_region == MBWA_REG_PF2 && !pick_we &&
     !(protect_en && last_prot_wr)) |=> cnt == 5'h02)
    else $error("frame read not two waits");
  a_prot_align: assert property (@(posedge clk) disable iff (rst) // RL16
    (state == MBWA_IDLE && !pick_we && protect_en && last_prot_wr &&
     (pick_region == MBWA_REG_PF1 || pick_region == MBWA_REG_PF2)) |=> cnt == 5'h03)
    else $error("protected read missing alignment cycle");
  a_otp_min: assert property (@(posedge clk) disable iff (rst) // RL4
    (state == MBWA_IDLE && pick_region == MBWA_REG_OTP) |=> cnt != 5'h00)
    else $error("otp below one wait");
  a_hold_ext: assert property (@(posedge clk) disable iff (rst) // RL6
    (state == MBWA_EXT && periph_hold) |=> !done && stall)
    else $error("stretched access released early");
  a_flash_wait: assert property (@(posedge clk) disable iff (rst) // RL2
    (state == MBWA_IDLE && pick_region == MBWA_REG_FLASH) |=> cnt == $past(flash_wait))
    else $error("flash wait not programmed value");
  a_pf2_narrow: assert property (@(posedge clk) disable iff (rst) // RL14
    (done && region == MBWA_REG_PF2 && wide) |-> access_error)
    else $error("wide frame two access accepted");
endmodule : mbwa_arbiter

// [verilog/mbwa_defs.svh]
`ifndef MBWA_DEFS_SVH
`define MBWA_DEFS_SVH
// Region wait-state counts
`define MBWA_WAIT_ZERO     5'h00
`define MBWA_WAIT_BOOT     5'h01
`define MBWA_WAIT_PWD      5'h10
`define MBWA_WAIT_OTP_MIN  5'h01
`define MBWA_WAIT_PF_RD    5'h02
`define MBWA_WAIT_PF1_WWB  5'h01
// Address map decode bounds (word addresses)
`define MBWA_LOW_RAM_END   32'h0000_07FF
`define MBWA_PF0_LO        32'h0000_0800
`define MBWA_PF0_HI        32'h0000_0FFF
`define MBWA_PF1_LO        32'h0000_6000
`define MBWA_PF1_HI        32'h0000_6FFF
`define MBWA_PF2_LO        32'h0000_7000
`define MBWA_PF2_HI        32'h0000_7FFF
`define MBWA_SRAM_LO       32'h0000_8000
`define MBWA_SRAM_HI       32'h0000_BFFF
`define MBWA_OTP_LO        32'h003D_7800
`define MBWA_OTP_HI        32'h003D_7BFF
`define MBWA_FLASH_LO      32'h003D_8000
`define MBWA_FLASH_HI      32'h003F_7FFF
`define MBWA_PWD_LO        32'h003F_7FF8
`define MBWA_BOOT_LO       32'h003F_F000
`endif

// [verilog/mbwa_pkg.sv]
package mbwa_pkg;
  typedef enum logic [3:0] {
    MBWA_REG_RAM   = 4'h0,
    MBWA_REG_PF0   = 4'h1,
    MBWA_REG_PF1   = 4'h2,
    MBWA_REG_PF2   = 4'h3,
    MBWA_REG_OTP   = 4'h4,
    MBWA_REG_FLASH = 4'h5,
    MBWA_REG_PWD   = 4'h6,
    MBWA_REG_BOOT  = 4'h7,
    MBWA_REG_NONE  = 4'h8
  } mbwa_region_t;
  typedef enum logic [1:0] {
    MBWA_IDLE = 2'b00,
    MBWA_WAIT = 2'b01,
    MBWA_EXT  = 2'b10
  } mbwa_state_t;
  // Requesters in grant priority order, highest first
  typedef enum logic [2:0] {
    MBWA_SRC_DWR  = 3'h0,
    MBWA_SRC_PWR  = 3'h1,
    MBWA_SRC_DRD  = 3'h2,
    MBWA_SRC_PRD  = 3'h3,
    MBWA_SRC_FET  = 3'h4,
    MBWA_SRC_NONE = 3'h7
  } mbwa_src_t;
endpackage : mbwa_pkg

// [verif/mbwa_far_model.sv]
// Memory and peripheral side: returns address-derived data and can stretch frame-1 accesses
module mbwa_far_model
  import mbwa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        grant_valid,
  input  wire logic [3:0]  mem_region,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  hold_len,
  output logic [31:0]      mem_rdata,
  output logic             periph_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cnt;
  logic [31:0] churn;
  // Count cycles of the current access; churn keeps idle data from looking valid
  always_ff @(posedge clk) begin
    cnt   <= (grant_valid && !rst) ? cnt + 4'h1 : 4'h0;
    churn <= rst ? 32'hA5A5_5A5A : ~churn;
  end
  // Stretch a frame-1 access for hold_len cycles from its start
  assign periph_hold = grant_valid && mem_region == 4'(MBWA_REG_PF1) && cnt < hold_len;
  assign mem_rdata   = grant_valid ? {mem_addr[15:0], ~mem_addr[15:0]} : churn;
endmodule : mbwa_far_model

// [verif/test_mbwa_arbiter.sv]
module test_mbwa_arbiter
  import mbwa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, protect_en, periph_hold, grant_valid, stall, done, access_error;
  logic fet_req, prd_req, pwr_req, drd_req, drd_wide, dwr_req, dwr_wide;
  logic mem_we, mem_wide, pbus_sel;
  logic [4:0]  flash_wait, otp_wait;
  logic [21:0] fet_addr, prd_addr, pwr_addr;
  logic [31:0] pwr_data, drd_addr, dwr_addr, dwr_data, mem_rdata, mem_addr, mem_wdata, rdata;
  logic [2:0]  grant_src;
  logic [3:0]  mem_region, hold_len;
  logic [15:0] pbus_addr;
  int mismatches, num_checks, cycles;

  mbwa_arbiter dut (.clk(clk), .rst(rst), .flash_wait(flash_wait), .otp_wait(otp_wait),
    .protect_en(protect_en), .fet_req(fet_req), .fet_addr(fet_addr), .prd_req(prd_req),
    .prd_addr(prd_addr), .pwr_req(pwr_req), .pwr_addr(pwr_addr), .pwr_data(pwr_data),
    .drd_req(drd_req), .drd_addr(drd_addr), .drd_wide(drd_wide), .dwr_req(dwr_req),
    .dwr_addr(dwr_addr), .dwr_data(dwr_data), .dwr_wide(dwr_wide), .mem_rdata(mem_rdata),
    .periph_hold(periph_hold), .grant_valid(grant_valid), .grant_src(grant_src),
    .stall(stall), .done(done), .access_error(access_error), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_wide(mem_wide), .mem_region(mem_region),
    .rdata(rdata), .pbus_sel(pbus_sel), .pbus_addr(pbus_addr));
  mbwa_far_model far (.clk(clk), .rst(rst), .grant_valid(grant_valid),
    .mem_region(mem_region), .mem_addr(mem_addr), .hold_len(hold_len),
    .mem_rdata(mem_rdata), .periph_hold(periph_hold));

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // One transfer; w < 0 skips the latency compare, keep leaves the request raised
  task automatic access(input mbwa_src_t src, input logic [31:0] addr, input logic wide,
                        input int w, input logic keep, input logic err, output int k);
    logic [31:0] d;
    logic        wr;
    logic        ew;
    d  = {addr[15:0], ~addr[15:0]};
    wr = (src == MBWA_SRC_DWR || src == MBWA_SRC_PWR);
    // Program-side buses always move a full 32-bit word
    ew = (src == MBWA_SRC_DWR || src == MBWA_SRC_DRD) ? wide : 1'b1;
    case (src)
      MBWA_SRC_DWR: begin dwr_req = 1'b1; dwr_addr = addr; dwr_wide = wide; dwr_data = d; end
      MBWA_SRC_PWR: begin pwr_req = 1'b1; pwr_addr = addr[21:0]; pwr_data = d; end
      MBWA_SRC_DRD: begin drd_req = 1'b1; drd_addr = addr; drd_wide = wide; end
      MBWA_SRC_PRD: begin prd_req = 1'b1; prd_addr = addr[21:0]; end
      default:      begin fet_req = 1'b1; fet_addr = addr[21:0]; end
    endcase
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (k == 1) begin
        chk("grant_src", 32'(src), 32'(grant_src));
        chk("mem_addr", addr, mem_addr);
        chk("mem_we", 32'(wr), 32'(mem_we));
        chk("mem_wide", 32'(ew), 32'(mem_wide));
        chk("stall", 32'h0000_0001, 32'(stall));
        chk("grant_valid", 32'h0000_0001, 32'(grant_valid));
        if (wr)
          chk("mem_wdata", d, mem_wdata);
        if (pbus_sel === 1'b1)
          chk("pbus_addr", 32'(addr[15:0]), 32'(pbus_addr));
      end
    end while (done !== 1'b1 && k < 40);
    if (w >= 0)
      chk("latency", 32'(w + 2), 32'(k));
    chk("stall idle", 32'h0000_0000, 32'(stall));
    chk("access_error", 32'(err), 32'(access_error));
    if (!wr)
      chk("rdata", d, rdata);
    if (!keep)
      case (src)
        MBWA_SRC_DWR: dwr_req = 1'b0;
        MBWA_SRC_PWR: pwr_req = 1'b0;
        MBWA_SRC_DRD: drd_req = 1'b0;
        MBWA_SRC_PRD: prd_req = 1'b0;
        default:      fet_req = 1'b0;
      endcase
  endtask : access

  task automatic idle();
    repeat (2) @(negedge clk);
  endtask : idle

  // Fixed-wait regions, reads then writes, an idle gap after each frame write
  task automatic t_fixed();
    int k;
    access(MBWA_SRC_DRD, 32'h0000_0100, 1'b1, 0, 1'b1, 1'b0, k);
    access(MBWA_SRC_DRD, 32'h0000_0800, 1'b0, 0, 1'b0, 1'b0, k);
    access(MBWA_SRC_PRD, 32'h0000_8000, 1'b0, 0, 1'b0, 1'b0, k);
    access(MBWA_SRC_FET, 32'h003F_F000, 1'b0, 1, 1'b0, 1'b0, k);
    access(MBWA_SRC_DRD, 32'h0000_6000, 1'b1, 2, 1'b1, 1'b0, k);
    access(MBWA_SRC_DRD, 32'h0000_7000, 1'b0, 2, 1'b0, 1'b0, k);
    access(MBWA_SRC_DWR, 32'h0000_6004, 1'b1, 0, 1'b0, 1'b0, k);
    idle();
    access(MBWA_SRC_DWR, 32'h0000_7004, 1'b0, 0, 1'b0, 1'b0, k);
    idle();
  endtask : t_fixed

  // Programmable flash, fixed password and clamped OTP counts
  task automatic t_prog();
    int k;
    flash_wait = 5'h00;
    access(MBWA_SRC_FET, 32'h003D_8000, 1'b0, 0, 1'b1, 1'b0, k);
    flash_wait = 5'h0F;
    access(MBWA_SRC_FET, 32'h003E_0000, 1'b0, 15, 1'b0, 1'b0, k);
    flash_wait = 5'h03;
    access(MBWA_SRC_DRD, 32'h003F_7FF8, 1'b0, 16, 1'b0, 1'b0, k);
    otp_wait = 5'h00;
    access(MBWA_SRC_PRD, 32'h003D_7800, 1'b0, 1, 1'b1, 1'b0, k);
    otp_wait = 5'h04;
    access(MBWA_SRC_PRD, 32'h003D_7BFF, 1'b0, 4, 1'b0, 1'b0, k);
  endtask : t_prog

  // Back-to-back frame-1 writes, then write-then-read ordering on and off
  task automatic t_order();
    int k;
    access(MBWA_SRC_DWR, 32'h0000_6000, 1'b0, 0, 1'b1, 1'b0, k);
    access(MBWA_SRC_DWR, 32'h0000_6002, 1'b0, 1, 1'b0, 1'b0, k);
    idle();
    access(MBWA_SRC_DWR, 32'h0000_6010, 1'b0, 0, 1'b1, 1'b0, k);
    dwr_req = 1'b0;
    access(MBWA_SRC_DRD, 32'h0000_7004, 1'b0, 3, 1'b0, 1'b0, k);
    idle();
    protect_en = 1'b0;
    access(MBWA_SRC_DWR, 32'h0000_6010, 1'b0, 0, 1'b1, 1'b0, k);
    dwr_req = 1'b0;
    access(MBWA_SRC_DRD, 32'h0000_7004, 1'b0, 2, 1'b0, 1'b0, k);
    protect_en = 1'b1;
    idle();
  endtask : t_order

  // Peripheral stretch, wide accesses, all five requesters pending at once
  task automatic t_misc();
    int k;
    hold_len = 4'h6;
    access(MBWA_SRC_DRD, 32'h0000_6020, 1'b0, -1, 1'b0, 1'b0, k);
    if (k < 7 || k > 14) begin
      mismatches++;
      $display("unexpected stretch latency: expected 7..14, seen %0d", k);
    end
    num_checks++;
    hold_len = 4'h0;
    access(MBWA_SRC_DWR, 32'h0000_7010, 1'b1, 0, 1'b0, 1'b1, k);
    idle();
    access(MBWA_SRC_DWR, 32'h0000_6030, 1'b1, 0, 1'b0, 1'b0, k);
    idle();
    {pwr_req, drd_req, prd_req, fet_req} = 4'hF;
    access(MBWA_SRC_DWR, 32'h0000_0010, 1'b0, 0, 1'b0, 1'b0, k);
    access(MBWA_SRC_PWR, 32'h0000_0020, 1'b0, 0, 1'b0, 1'b0, k);
    access(MBWA_SRC_DRD, 32'h0000_0030, 1'b0, 0, 1'b0, 1'b0, k);
    access(MBWA_SRC_PRD, 32'h0000_0040, 1'b0, 0, 1'b0, 1'b0, k);
    access(MBWA_SRC_FET, 32'h0000_0050, 1'b0, 0, 1'b0, 1'b0, k);
  endtask : t_misc

  // Clock source
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard: far above the fewer than two hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    {rst, protect_en} = 2'b11;
    {fet_req, prd_req, pwr_req, drd_req, dwr_req, drd_wide, dwr_wide} = 7'h00;
    {fet_addr, prd_addr, pwr_addr} = '0;
    {pwr_data, drd_addr, dwr_addr, dwr_data} = '0;
    flash_wait = 5'h02;
    otp_wait   = 5'h02;
    hold_len   = 4'h0;
    mismatches = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (3) @(negedge clk);
    chk("reset grant_src", 32'h0000_0007, 32'(grant_src));
    chk("reset mem_region", 32'h0000_0008, 32'(mem_region));
    chk("reset stall", 32'h0000_0000, 32'(stall));
    rst = 1'b0;
    t_fixed();
    t_prog();
    t_order();
    t_misc();
    idle();
    conclude();
  end
endmodule : test_mbwa_arbiter
